// >>> cmfsc_pkg.sv
// Package for the clock mode and loop status/control block.
// Assumes a single 25 MHz bus clock; reference clocks arrive as sampled inputs.
package cmfsc_pkg;

   // Register indices on the plain register port.
   localparam logic [2:0] CMFSC_ADDR_CTRL1  = 3'h0;
   localparam logic [2:0] CMFSC_ADDR_CTRL2  = 3'h1;
   localparam logic [2:0] CMFSC_ADDR_STATUS = 3'h2;
   localparam logic [2:0] CMFSC_ADDR_MODE   = 3'h3;

   // Field positions in the status and range control register.
   localparam int CMFSC_RANGE_LSB  = 6;
   localparam int CMFSC_MAXF_BIT   = 5;
   localparam int CMFSC_REFST_BIT  = 4;
   localparam int CMFSC_CLOCK_MODE_STATUS_LSB  = 2;
   localparam int CMFSC_OSCRDY_BIT = 1;
   localparam int CMFSC_FINE_TRIM_BIT  = 0;

   // Field positions in control register 1.
   localparam int CMFSC_SRC_LSB     = 6;
   localparam int CMFSC_DIV_LSB     = 3;
   localparam int CMFSC_REFSEL_BIT  = 2;
   localparam int CMFSC_IROE_BIT    = 1;
   localparam int CMFSC_IRSTOP_BIT  = 0;

   // Field positions in control register 2.
   localparam int CMFSC_LP_BIT      = 3;
   localparam int CMFSC_OSCREQ_BIT  = 2;
   localparam int CMFSC_EROE_BIT    = 1;
   localparam int CMFSC_ERSTOP_BIT  = 0;

   // Values after reset.
   localparam logic [7:0] CMFSC_CTRL1_RST = 8'h04;
   localparam logic [7:0] CMFSC_CTRL2_RST = 8'h00;
   localparam logic [1:0] CMFSC_RANGE_RST = 2'h0;

   // Range codes and loop multipliers.
   localparam logic [1:0] CMFSC_RANGE_LOW  = 2'h0;
   localparam logic [1:0] CMFSC_RANGE_MID  = 2'h1;
   localparam logic [1:0] CMFSC_RANGE_HIGH = 2'h2;
   localparam logic [1:0] CMFSC_RANGE_RSV  = 2'h3;
   localparam logic [10:0] CMFSC_MULT_LOW   = 11'h200;
   localparam logic [10:0] CMFSC_MULT_MID   = 11'h400;
   localparam logic [10:0] CMFSC_MULT_HIGH  = 11'h600;
   localparam logic [10:0] CMFSC_MULTX_LOW  = 11'h260;
   localparam logic [10:0] CMFSC_MULTX_MID  = 11'h4C0;
   localparam logic [10:0] CMFSC_MULTX_HIGH = 11'h720;

   // Source select codes.
   localparam logic [1:0] CMFSC_SRC_LOOP = 2'h0;
   localparam logic [1:0] CMFSC_SRC_IREF = 2'h1;
   localparam logic [1:0] CMFSC_SRC_EREF = 2'h2;

   // Oscillator start-up time and its cycle count.
   localparam int CMFSC_OSC_START_US  = 40;
   localparam int CMFSC_CLK_MHZ       = 25;
   localparam int CMFSC_OSC_START_CYC = CMFSC_OSC_START_US * CMFSC_CLK_MHZ;
   // New oscillator range start-up delay in cycles.
   localparam int CMFSC_RANGE_START_CYC = 16;

   typedef enum logic [2:0] {
      CMFSC_MODE_ENG_INT,
      CMFSC_MODE_ENG_EXT,
      CMFSC_MODE_BYP_INT,
      CMFSC_MODE_BYP_INT_LP,
      CMFSC_MODE_BYP_EXT,
      CMFSC_MODE_BYP_EXT_LP,
      CMFSC_MODE_STOP
   } cmfsc_mode_e;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cmfsc_bus_s;

   typedef struct packed {
      logic unit_clock_en;
      logic debug_local_clock_en;
      logic int_ref_clock_en;
      logic ext_ref_clock_en;
      logic loop_enable;
   } cmfsc_clk_s;

endpackage : cmfsc_pkg

// >>> cmfsc_top.sv
// Status and control logic of the clock unit with frequency-locked loop.
// Assumes one 25 MHz clock; all pin inputs are synchronous to it except the
// oscillator running level, which comes from the analogue side and is synchronised.
`timescale 1ns/100ps
`default_nettype none
module cmfsc_top
   import cmfsc_pkg::*;
#(
   parameter int OSC_START_CYC = CMFSC_OSC_START_CYC
) (
   input  wire logic                  clock_in,           // Bus clock.
   input  wire logic                  rst_in,             // Synchronous reset, high.
   input  wire cmfsc_pkg::cmfsc_bus_s bus_in,             // Register request.
   output logic [7:0]                 rdata_out,          // Read data, cycle after read.
   input  wire logic                  factory_trim_in,    // Factory fine trim value.
   input  wire logic                  debug_active_in,    // Background debug active.
   input  wire logic                  stop_in,            // System stop request.
   input  wire logic                  osc_running_in,     // External oscillator toggling.
   output cmfsc_pkg::cmfsc_clk_s      clk_out,            // Clock gate enables.
   output cmfsc_pkg::cmfsc_mode_e     mode_out,           // Current operating mode.
   output logic [10:0]                multiplier_out,     // Loop multiplier in use.
   output logic [1:0]                 range_active_out,   // Oscillator range in use.
   output logic                       fine_trim_out       // Fine trim to oscillator.
);
   import cmfsc_pkg::*;

   logic [7:0]   ctrl1_q;
   logic [7:0]   ctrl2_q;
   logic [1:0]   range_sel_q;
   logic         max_tune_q;
   logic         fine_trim_q;
   logic         trim_loaded_q;
   logic [1:0]   range_use_q;
   logic [4:0]   range_cnt_q;
   logic         ref_use_q;
   logic [1:0]   src_use_q;
   logic [1:0]   sync_ref_q;
   logic [3:0]   sync_src_q;
   logic [3:0]   sync_rng_q;
   logic         osc_rdy_q;
   logic [15:0]  osc_cnt_q;
   logic [1:0]   osc_sync_q;
   logic [7:0]   rdata_q;
   cmfsc_mode_e  mode_q;
   cmfsc_mode_e  mode_d;
   cmfsc_clk_s   clk_q;
   cmfsc_clk_s   clk_d;
   logic [10:0]  mult_q;
   logic [10:0]  mult_d;

   logic        wr1;
   logic        wr2;
   logic        wrs;
   logic [1:0]  src_sel;
   logic        ref_sel;
   logic        lp;
   logic        ext_needed;
   logic        src_ok;
   logic        eroe_fall;

   assign wr1     = bus_in.wr && (bus_in.addr == CMFSC_ADDR_CTRL1);
   assign wr2     = bus_in.wr && (bus_in.addr == CMFSC_ADDR_CTRL2);
   assign wrs     = bus_in.wr && (bus_in.addr == CMFSC_ADDR_STATUS);
   assign ref_sel = ctrl1_q[CMFSC_REFSEL_BIT];
   assign lp      = ctrl2_q[CMFSC_LP_BIT];
   // Reserved source code falls back to loop output.
   assign src_sel = (ctrl1_q[CMFSC_SRC_LSB +: 2] == CMFSC_RANGE_RSV) ? CMFSC_SRC_LOOP
                                                                     : ctrl1_q[CMFSC_SRC_LSB +: 2];
   assign ext_needed = ctrl2_q[CMFSC_EROE_BIT] || !ref_use_q || (src_use_q == CMFSC_SRC_EREF) ||
                       (src_sel == CMFSC_SRC_EREF);
   // External source is usable only once the oscillator is ready or no crystal is requested.
   assign src_ok  = (src_sel != CMFSC_SRC_EREF) || !ctrl2_q[CMFSC_OSCREQ_BIT] || osc_rdy_q;
   // Ready clears on the write that drops the output enable, not on its level, so an
   // external mode with the output enable off can still bring the oscillator up.
   assign eroe_fall = wr2 && ctrl2_q[CMFSC_EROE_BIT] && !bus_in.wdata[CMFSC_EROE_BIT];

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ctrl1_q <= CMFSC_CTRL1_RST;
         ctrl2_q <= CMFSC_CTRL2_RST;
      end else begin
         if (wr1) begin
            ctrl1_q <= bus_in.wdata;
         end
         if (wr2) begin
            ctrl2_q <= bus_in.wdata;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         range_sel_q <= CMFSC_RANGE_RST;
         max_tune_q  <= 1'b0;
      end else if (wrs) begin
         max_tune_q <= bus_in.wdata[CMFSC_MAXF_BIT];
         if (!lp && bus_in.wdata[CMFSC_RANGE_LSB +: 2] != CMFSC_RANGE_RSV) begin
            range_sel_q <= bus_in.wdata[CMFSC_RANGE_LSB +: 2];
         end
      end
   end

   // Fine trim is caught on the first cycle after reset release.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         fine_trim_q   <= 1'b0;
         trim_loaded_q <= 1'b0;
      end else if (!trim_loaded_q) begin
         trim_loaded_q <= 1'b1;
         fine_trim_q   <= debug_active_in ? 1'b0 : factory_trim_in;
      end else if (wrs) begin
         fine_trim_q <= bus_in.wdata[CMFSC_FINE_TRIM_BIT];
      end
   end

   // Two-stage synchronisers model the crossing into the bus domain.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         sync_ref_q <= 2'h3;
         sync_src_q <= 4'h0;
         sync_rng_q <= 4'h0;
      end else begin
         sync_ref_q <= {sync_ref_q[0], ref_sel};
         sync_src_q <= {sync_src_q[1:0], src_ok ? src_sel : src_use_q};
         sync_rng_q <= {sync_rng_q[1:0], range_sel_q};
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ref_use_q <= 1'b1;
         src_use_q <= CMFSC_SRC_LOOP;
      end else begin
         ref_use_q <= sync_ref_q[1];
         src_use_q <= sync_src_q[3:2];
      end
   end

   // In engaged modes the active range moves only after the new range has started.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         range_use_q <= CMFSC_RANGE_RST;
         range_cnt_q <= 5'h0;
      end else if (sync_rng_q[3:2] == range_use_q) begin
         range_cnt_q <= 5'h0;
      end else if (src_use_q != CMFSC_SRC_LOOP || range_cnt_q == 5'(CMFSC_RANGE_START_CYC)) begin
         range_use_q <= sync_rng_q[3:2];
         range_cnt_q <= 5'h0;
      end else begin
         range_cnt_q <= range_cnt_q + 5'h1;
      end
   end

   // Oscillator ready after start-up; cleared only by enable or request clear.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         osc_sync_q <= 2'h0;
         osc_cnt_q  <= 16'h0;
         osc_rdy_q  <= 1'b0;
      end else begin
         osc_sync_q <= {osc_sync_q[0], osc_running_in};
         if (eroe_fall || !ctrl2_q[CMFSC_OSCREQ_BIT]) begin
            osc_rdy_q <= 1'b0;
            osc_cnt_q <= 16'h0;
         end else if (ext_needed && osc_sync_q[1] && !osc_rdy_q) begin
            if (osc_cnt_q == 16'(OSC_START_CYC - 1)) begin
               osc_rdy_q <= 1'b1;
            end else begin
               osc_cnt_q <= osc_cnt_q + 16'h1;
            end
         end
      end
   end

   always_comb begin
      case (src_use_q)
         CMFSC_SRC_LOOP: mode_d = ref_use_q ? CMFSC_MODE_ENG_INT : CMFSC_MODE_ENG_EXT;
         CMFSC_SRC_IREF: mode_d = (lp && !debug_active_in) ? CMFSC_MODE_BYP_INT_LP
                                                          : CMFSC_MODE_BYP_INT;
         CMFSC_SRC_EREF: mode_d = (lp && !debug_active_in) ? CMFSC_MODE_BYP_EXT_LP
                                                          : CMFSC_MODE_BYP_EXT;
         default:        mode_d = CMFSC_MODE_ENG_INT;
      endcase
      if (stop_in) begin
         mode_d = CMFSC_MODE_STOP;
      end
   end

   always_comb begin
      clk_d = '0;
      case (mode_d)
         CMFSC_MODE_STOP: begin
            clk_d.int_ref_clock_en = ctrl1_q[CMFSC_IROE_BIT] && ctrl1_q[CMFSC_IRSTOP_BIT];
            clk_d.ext_ref_clock_en = ctrl2_q[CMFSC_EROE_BIT] && ctrl2_q[CMFSC_ERSTOP_BIT];
         end
         CMFSC_MODE_BYP_INT_LP, CMFSC_MODE_BYP_EXT_LP: begin
            clk_d.unit_clock_en    = 1'b1;
            clk_d.int_ref_clock_en = ctrl1_q[CMFSC_IROE_BIT];
            clk_d.ext_ref_clock_en = ctrl2_q[CMFSC_EROE_BIT];
         end
         default: begin
            clk_d.unit_clock_en        = 1'b1;
            clk_d.debug_local_clock_en = 1'b1;
            clk_d.loop_enable          = 1'b1;
            clk_d.int_ref_clock_en     = ctrl1_q[CMFSC_IROE_BIT];
            clk_d.ext_ref_clock_en     = ctrl2_q[CMFSC_EROE_BIT];
         end
      endcase
   end

   always_comb begin
      case (range_use_q)
         CMFSC_RANGE_LOW:  mult_d = max_tune_q ? CMFSC_MULTX_LOW  : CMFSC_MULT_LOW;
         CMFSC_RANGE_MID:  mult_d = max_tune_q ? CMFSC_MULTX_MID  : CMFSC_MULT_MID;
         CMFSC_RANGE_HIGH: mult_d = max_tune_q ? CMFSC_MULTX_HIGH : CMFSC_MULT_HIGH;
         default:          mult_d = CMFSC_MULT_LOW;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         mode_q <= CMFSC_MODE_ENG_INT;
         clk_q  <= '0;
         mult_q <= CMFSC_MULT_LOW;
      end else begin
         mode_q <= mode_d;
         clk_q  <= clk_d;
         mult_q <= mult_d;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rdata_q <= 8'h00;
      end else if (bus_in.rd) begin
         case (bus_in.addr)
            CMFSC_ADDR_CTRL1:  rdata_q <= ctrl1_q;
            CMFSC_ADDR_CTRL2:  rdata_q <= ctrl2_q;
            CMFSC_ADDR_STATUS: rdata_q <= {range_use_q, max_tune_q, ref_use_q,
                                           src_use_q, osc_rdy_q, fine_trim_q};
            CMFSC_ADDR_MODE:   rdata_q <= {5'h00, mode_q};
            default:           rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata_out        = rdata_q;
   assign clk_out          = clk_q;
   assign mode_out         = mode_q;
   assign multiplier_out   = mult_q;
   assign range_active_out = range_use_q;
   assign fine_trim_out    = fine_trim_q;

endmodule : cmfsc_top
`default_nettype wire

// >>> cmfsc_monitor.sv
// Assertion checker for the clock mode and loop status block.
// Bound to cmfsc_top; it shadows the two control registers from bus writes.
`timescale 1ns/100ps
`default_nettype none
module cmfsc_monitor
   import cmfsc_pkg::*;
#(
   parameter int OSC_START_CYC = CMFSC_OSC_START_CYC
) (
   input wire logic                   clock_in,         // Clock.
   input wire logic                   rst_in,           // Reset.
   input wire cmfsc_pkg::cmfsc_bus_s  bus_in,           // Bus.
   input wire logic                   factory_trim_in,  // Trim.
   input wire logic                   debug_active_in,  // Debug.
   input wire logic                   stop_in,          // Stop.
   input wire cmfsc_pkg::cmfsc_clk_s  clk_out,          // Gates.
   input wire cmfsc_pkg::cmfsc_mode_e mode_out,         // Mode.
   input wire logic [10:0]            multiplier_out,   // Multiplier.
   input wire logic [1:0]             range_active_out, // Range.
   input wire logic                   fine_trim_out     // Trim out.
);
   import cmfsc_pkg::*;
   logic [7:0] c1_q;
   logic [7:0] c2_q;
   logic [4:0] lp_cnt_q;
   logic       wr_st;
   assign wr_st = bus_in.wr && (bus_in.addr == CMFSC_ADDR_STATUS);
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         c1_q <= CMFSC_CTRL1_RST;
         c2_q <= CMFSC_CTRL2_RST;
      end else if (bus_in.wr && bus_in.addr == CMFSC_ADDR_CTRL1) begin
         c1_q <= bus_in.wdata;
      end else if (bus_in.wr && bus_in.addr == CMFSC_ADDR_CTRL2) begin
         c2_q <= bus_in.wdata;
      end
   end
   // Counts how long the low-power bit has been set, so in-flight range moves are excluded.
   always_ff @(posedge clock_in) begin
      if (rst_in || !c2_q[CMFSC_LP_BIT]) begin
         lp_cnt_q <= 5'h00;
      end else if (lp_cnt_q != 5'h1F) begin
         lp_cnt_q <= lp_cnt_q + 5'h01;
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   AST_RANGE_NO_RSV: assert property (range_active_out != CMFSC_RANGE_RSV)
      else $error("range in use holds the reserved code");
   AST_MULT_MATCH: assert property ($stable(range_active_out) [*3] |->
      (range_active_out == CMFSC_RANGE_LOW && multiplier_out inside {CMFSC_MULT_LOW, CMFSC_MULTX_LOW}) ||
      (range_active_out == CMFSC_RANGE_MID && multiplier_out inside {CMFSC_MULT_MID, CMFSC_MULTX_MID}) ||
      (range_active_out == CMFSC_RANGE_HIGH && multiplier_out inside {CMFSC_MULT_HIGH, CMFSC_MULTX_HIGH}))
      else $error("multiplier does not match range");
   AST_RANGE_LAG: assert property ($changed(range_active_out) |-> !$past(wr_st) && !$past(wr_st, 2))
      else $error("range moved right after a status write");
   AST_LP_HOLD: assert property (lp_cnt_q == 5'h1F |-> $stable(range_active_out))
      else $error("range moved under low power");
   AST_STOP_GATES: assert property (stop_in [*3] |-> mode_out == CMFSC_MODE_STOP &&
      !clk_out.unit_clock_en && !clk_out.debug_local_clock_en && !clk_out.loop_enable)
      else $error("clock not static in stop");
   AST_STOP_IREF: assert property (stop_in [*3] ##0 clk_out.int_ref_clock_en |->
      c1_q[CMFSC_IROE_BIT] && c1_q[CMFSC_IRSTOP_BIT])
      else $error("internal reference kept in stop without enables");
   AST_STOP_EREF: assert property (stop_in [*3] ##0 clk_out.ext_ref_clock_en |->
      c2_q[CMFSC_EROE_BIT] && c2_q[CMFSC_ERSTOP_BIT])
      else $error("external reference kept in stop without enables");
   AST_FINE_TRIM_LOAD: assert property ($fell(rst_in) |-> ##2 fine_trim_out == (factory_trim_in && !debug_active_in))
      else $error("fine trim not loaded at reset");
   AST_LOOP_ON: assert property (!$past(rst_in) && !$past(rst_in, 2) && $stable(mode_out) &&
      mode_out inside {CMFSC_MODE_ENG_INT, CMFSC_MODE_ENG_EXT, CMFSC_MODE_BYP_INT, CMFSC_MODE_BYP_EXT} |->
      clk_out.loop_enable && clk_out.debug_local_clock_en && clk_out.unit_clock_en)
      else $error("loop or debug clock off in a loop mode");
   AST_LOOP_OFF: assert property ($stable(mode_out) &&
      mode_out inside {CMFSC_MODE_BYP_INT_LP, CMFSC_MODE_BYP_EXT_LP} |->
      !clk_out.loop_enable && !clk_out.debug_local_clock_en)
      else $error("loop or debug clock on in low power");
   COV_STOP: cover property (mode_out == CMFSC_MODE_STOP);
   COV_EXT_LP: cover property (mode_out == CMFSC_MODE_BYP_EXT_LP);
   COV_RANGE: cover property ($changed(range_active_out));
endmodule : cmfsc_monitor
bind cmfsc_top cmfsc_monitor #(.OSC_START_CYC(OSC_START_CYC)) mon_u (.clock_in(clock_in), .rst_in(rst_in),
   .bus_in(bus_in), .factory_trim_in(factory_trim_in), .debug_active_in(debug_active_in), .stop_in(stop_in),
   .clk_out(clk_out), .mode_out(mode_out), .multiplier_out(multiplier_out), .range_active_out(range_active_out),
   .fine_trim_out(fine_trim_out));
`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the clock mode and loop status block.
// Drives cmfsc_top directly; the checker is attached by bind.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import cmfsc_pkg::*;
   localparam logic [7:0]  M_C1 [8] = '{8'h04, 8'h00, 8'h44, 8'h44, 8'h44, 8'h80, 8'h80, 8'hC4};
   localparam logic [7:0]  M_C2 [8] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08, 8'h00};
   localparam logic [7:0]  M_DB     = 8'h10;
   localparam cmfsc_mode_e M_EX [8] = '{CMFSC_MODE_ENG_INT, CMFSC_MODE_ENG_EXT, CMFSC_MODE_BYP_INT,
      CMFSC_MODE_BYP_INT_LP, CMFSC_MODE_BYP_INT, CMFSC_MODE_BYP_EXT, CMFSC_MODE_BYP_EXT_LP, CMFSC_MODE_ENG_INT};
   logic        clock_in, rst_in, fine_trim_in, dbg_in, stop_in, osc_in, fine_trim, t, f;
   cmfsc_bus_s  bus;
   cmfsc_clk_s  clk;
   cmfsc_mode_e mode;
   logic [7:0]  rdata, d;
   logic [10:0] mult;
   logic [1:0]  rng, r, prev;
   logic [31:0] lfsr;
   int          err_count, checked;
   cmfsc_top #(.OSC_START_CYC(4)) dut_u (.clock_in(clock_in), .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata),
      .factory_trim_in(fine_trim_in), .debug_active_in(dbg_in), .stop_in(stop_in), .osc_running_in(osc_in),
      .clk_out(clk), .mode_out(mode), .multiplier_out(mult), .range_active_out(rng), .fine_trim_out(fine_trim));
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd
   function automatic logic [10:0] exp_mult(logic [1:0] rs, logic ts);
      case (rs)
         CMFSC_RANGE_MID:  return ts ? CMFSC_MULTX_MID : CMFSC_MULT_MID;
         CMFSC_RANGE_HIGH: return ts ? CMFSC_MULTX_HIGH : CMFSC_MULT_HIGH;
         default:          return ts ? CMFSC_MULTX_LOW : CMFSC_MULT_LOW;
      endcase
   endfunction : exp_mult
   task automatic cyc(int n);
      repeat (n) @(posedge clock_in);
   endtask : cyc
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(logic [2:0] a, logic [7:0] v);
      @(posedge clock_in);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clock_in);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [2:0] a);
      @(posedge clock_in);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock_in);
      bus.rd <= 1'b0;
      @(posedge clock_in);
      d = rdata;
   endtask : rd
   task automatic do_reset();
      @(posedge clock_in);
      rst_in <= 1'b1;
      cyc(6);
      rst_in <= 1'b0;
      cyc(3);
   endtask : do_reset
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      cyc(90000);
      err_count++;
      wrap_up();
   end
   initial begin
      rst_in = 1'b1;
      bus = '0;
      fine_trim_in = 1'b1;
      dbg_in = 1'b0;
      stop_in = 1'b0;
      osc_in = 1'b0;
      lfsr = 32'h000122D4;
      do_reset();
      chk("fine trim port", fine_trim, 1'b1);
      rd(CMFSC_ADDR_CTRL1);
      chk("ctrl1 reset", d, CMFSC_CTRL1_RST);
      rd(3'h5);
      chk("unmapped read", d, 8'h00);
      $display("reset test done");
      prev = CMFSC_RANGE_RST;
      for (int i = 0; i < 6; i++) begin
         r = 2'(i % 3);
         t = (i > 2);
         f = 1'(rnd());
         wr(CMFSC_ADDR_STATUS, {r, t, 4'h0, f});
         chk("range early", rng, prev);
         cyc(10);
         chk("range before start-up", rng, prev);
         cyc(20);
         chk("range", rng, r);
         chk("multiplier", mult, exp_mult(r, t));
         chk("fine trim port", fine_trim, f);
         rd(CMFSC_ADDR_STATUS);
         chk("status fields", {d[7:5], d[0]}, {r, t, f});
         prev = r;
      end
      wr(CMFSC_ADDR_STATUS, 8'hE0);
      cyc(30);
      chk("reserved range", rng, prev);
      wr(CMFSC_ADDR_CTRL2, 8'h08);
      wr(CMFSC_ADDR_STATUS, 8'h00);
      cyc(30);
      chk("range under low power", rng, prev);
      $display("range test done");
      for (int i = 0; i < 8; i++) begin
         dbg_in <= M_DB[i];
         wr(CMFSC_ADDR_CTRL2, M_C2[i]);
         wr(CMFSC_ADDR_CTRL1, M_C1[i] | {2'h0, 3'(rnd()), 3'h0});
         cyc(30);
         chk("mode", mode, M_EX[i]);
         rd(CMFSC_ADDR_STATUS);
         chk("reference status", d[4], M_C1[i][2]);
         chk("clock mode status", d[3:2], (M_C1[i][7:6] == 2'h3) ? 2'h0 : M_C1[i][7:6]);
      end
      $display("mode test done");
      dbg_in <= 1'b0;
      wr(CMFSC_ADDR_CTRL1, 8'h44);
      wr(CMFSC_ADDR_CTRL2, 8'h06);
      wr(CMFSC_ADDR_CTRL1, 8'h80);
      cyc(30);
      chk("held source", mode, CMFSC_MODE_BYP_INT);
      rd(CMFSC_ADDR_STATUS);
      chk("ready early", d[1], 1'b0);
      osc_in <= 1'b1;
      cyc(30);
      chk("external source", mode, CMFSC_MODE_BYP_EXT);
      rd(CMFSC_ADDR_STATUS);
      chk("ready set", d[1], 1'b1);
      osc_in <= 1'b0;
      cyc(10);
      rd(CMFSC_ADDR_STATUS);
      chk("ready kept", d[1], 1'b1);
      wr(CMFSC_ADDR_CTRL2, 8'h04);
      cyc(10);
      rd(CMFSC_ADDR_STATUS);
      chk("ready cleared", d[1], 1'b0);
      osc_in <= 1'b1;
      cyc(30);
      rd(CMFSC_ADDR_STATUS);
      chk("ready in external mode", d[1], 1'b1);
      $display("oscillator test done");
      for (int i = 0; i < 4; i++) begin
         wr(CMFSC_ADDR_CTRL1, {7'h03, i[0]});
         wr(CMFSC_ADDR_CTRL2, {7'h01, i[1]});
         stop_in <= 1'b1;
         cyc(6);
         chk("stop mode", mode, CMFSC_MODE_STOP);
         chk("stop gates", clk, {2'b00, i[0], i[1], 1'b0});
         stop_in <= 1'b0;
         cyc(6);
      end
      $display("stop test done");
      dbg_in <= 1'b1;
      do_reset();
      chk("fine trim under debug", fine_trim, 1'b0);
      $display("debug reset test done");
      wrap_up();
   end
endmodule : tb
`default_nettype wire
